/* hdl/sakm_mix.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// keyed mixing round: stands in for the block cipher core
// ---------------------------------------------------------------
module sakm_mix (
   input  wire logic [sakm_pkg::KEY_W-1:0] key,
   input  wire logic [sakm_pkg::KEY_W-1:0] din,
   input  wire logic [31:0]                tweak,
   output logic      [sakm_pkg::KEY_W-1:0] dout
);
   logic [sakm_pkg::KEY_W-1:0] seed;
   logic [sakm_pkg::KEY_W-1:0] stir;
   logic [sakm_pkg::KEY_W-1:0] pad;

   // pad depends on key and tweak only, so replaying the same rounds unwraps
   always_comb begin
      seed = key ^ {8{tweak}};
      stir = seed + {seed[sakm_pkg::KEY_W-14:0], seed[sakm_pkg::KEY_W-1:sakm_pkg::KEY_W-13]};
      stir = stir ^ {stir[sakm_pkg::KEY_W-8:0], stir[sakm_pkg::KEY_W-1:sakm_pkg::KEY_W-7]};
      pad  = stir + {stir[sakm_pkg::KEY_W-30:0], stir[sakm_pkg::KEY_W-1:sakm_pkg::KEY_W-29]};
      dout = din ^ pad;
   end
endmodule : sakm_mix
`default_nettype wire

/* hdl/sakm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sakm_top (
   input  wire logic                         clk,
   input  wire logic                         rstn,
   // ---- root key load, write only
   input  wire logic                         mkWrite,
   input  wire logic                         wkWrite,
   input  wire logic [sakm_pkg::KEY_W-1:0]   keyWdata,
   // ---- control-plane fifo
   input  wire logic                         cmdValid,
   output logic                              cmdReady,
   input  wire sakm_pkg::sakm_cmd_t          cmd,
   input  wire logic                         ecbRequest,
   // ---- database memory, receive and transmit
   output sakm_pkg::sakm_mem_req_t           rxMemReq,
   output sakm_pkg::sakm_mem_req_t           txMemReq,
   input  wire logic                         rxMemAck,
   input  wire logic                         txMemAck,
   input  wire logic [sakm_pkg::WORD_W-1:0]  rxMemRdata,
   input  wire logic [sakm_pkg::WORD_W-1:0]  txMemRdata,
   // ---- data-plane key and status
   output sakm_pkg::sakm_dp_key_t            dpKey,
   output logic                              keysLoaded,
   output logic                              cmdError
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE,
      S_MIX,
      S_WRITE,
      S_READ,
      S_DONE
   } sakm_state_t;

   typedef struct packed {
      sakm_state_t                       state;
      logic [sakm_pkg::KEY_W-1:0]        master;
      logic [sakm_pkg::KEY_W-1:0]        wrap;
      logic                              mkSet;
      logic                              wkSet;
      sakm_pkg::sakm_cmd_t               cur;
      logic [sakm_pkg::KEY_W-1:0]        work;
      logic [sakm_pkg::KEY_W-1:0]        tag;
      logic [sakm_pkg::RCNT_W-1:0]       round;
      logic [sakm_pkg::WCNT_W-1:0]       word;
      logic                              memValid;
      sakm_pkg::sakm_dp_key_t            out;
      logic                              err;
   } sakm_regs_t;

   sakm_regs_t state_ff;
   sakm_regs_t nxt_state;

   logic [sakm_pkg::KEY_W-1:0] mixKey;
   logic [sakm_pkg::KEY_W-1:0] mixOut;
   logic [31:0]                mixTweak;
   logic                       memAck;
   logic [sakm_pkg::WORD_W-1:0] memRdata;
   logic                       usable;
   logic                       lastRound;
   logic                       lastWord;
   sakm_pkg::sakm_mem_req_t    memReq;

   // ---------------------------------------------------------------
   // cipher core
   // ---------------------------------------------------------------
   sakm_mix u_mix (
      .key   (mixKey),
      .din   (state_ff.work),
      .tweak (mixTweak),
      .dout  (mixOut)
   );

   always_comb begin
      // kdf runs from master key, wrap/unwrap from wrapping key
      if (state_ff.cur.op == sakm_pkg::SAKM_OP_DERIVE) begin
         mixKey = state_ff.master;
      end else begin
         mixKey = state_ff.wrap;
      end
      // tweak carries kdf counter, label and entry index
      mixTweak = sakm_pkg::KDF_LABEL
                 ^ {22'h00_0000, state_ff.round, state_ff.cur.index};
   end

   assign usable    = state_ff.mkSet & state_ff.wkSet;
   assign lastRound = (state_ff.round == sakm_pkg::RCNT_W'(sakm_pkg::ROUNDS - 1));
   assign lastWord  = (state_ff.word == sakm_pkg::WCNT_W'(sakm_pkg::ENTRY_WORDS - 1));
   assign memAck    = state_ff.cur.dirTx ? txMemAck : rxMemAck;
   assign memRdata  = state_ff.cur.dirTx ? txMemRdata : rxMemRdata;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state           = state_ff;
      nxt_state.out.valid = 1'b0;
      nxt_state.err       = 1'b0;
      // root keys enter only; nothing reads them out
      if (mkWrite) begin
         nxt_state.master = keyWdata;
         nxt_state.mkSet  = 1'b1;
      end
      if (wkWrite) begin
         nxt_state.wrap  = keyWdata;
         nxt_state.wkSet = 1'b1;
      end
      unique case (state_ff.state)
         S_IDLE: begin
            if (cmdValid) begin
               nxt_state.cur   = cmd;
               nxt_state.round = '0;
               nxt_state.word  = '0;
               nxt_state.tag   = '0;
               if (!usable || ecbRequest) begin
                  nxt_state.err     = 1'b1;
                  nxt_state.cur.key = sakm_pkg::KEY_RST;
               end else begin
                  unique case (cmd.op)
                     sakm_pkg::SAKM_OP_ADD: begin
                        nxt_state.work = cmd.keyIs256 ? cmd.key
                                         : {128'h0, cmd.key[127:0]};
                        nxt_state.state = S_MIX;
                     end
                     sakm_pkg::SAKM_OP_DELETE: begin
                        nxt_state.work     = sakm_pkg::KEY_RST;
                        nxt_state.memValid = 1'b1;
                        nxt_state.state    = S_WRITE;
                     end
                     sakm_pkg::SAKM_OP_FETCH: begin
                        nxt_state.memValid = 1'b1;
                        nxt_state.state    = S_READ;
                     end
                     sakm_pkg::SAKM_OP_DERIVE: begin
                        nxt_state.work  = {8{sakm_pkg::KDF_LABEL}};
                        nxt_state.state = S_MIX;
                     end
                  endcase
               end
            end
         end
         S_MIX: begin
            nxt_state.work  = mixOut;
            nxt_state.tag   = state_ff.tag ^ mixOut;
            nxt_state.round = state_ff.round + 1'b1;
            if (lastRound) begin
               unique case (state_ff.cur.op)
                  sakm_pkg::SAKM_OP_ADD: begin
                     nxt_state.memValid = 1'b1;
                     nxt_state.state    = S_WRITE;
                  end
                  sakm_pkg::SAKM_OP_FETCH: begin
                     nxt_state.out.valid  = 1'b1;
                     nxt_state.out.dirTx  = state_ff.cur.dirTx;
                     nxt_state.out.authOk = 1'b1;
                     nxt_state.out.key    = mixOut;
                     nxt_state.state      = S_DONE;
                  end
                  default: begin
                     nxt_state.out.valid  = 1'b1;
                     nxt_state.out.dirTx  = state_ff.cur.dirTx;
                     nxt_state.out.authOk = 1'b1;
                     nxt_state.out.key    = mixOut;
                     nxt_state.state      = S_DONE;
                  end
               endcase
            end
         end
         S_WRITE: begin
            if (memAck) begin
               nxt_state.work = state_ff.work >> sakm_pkg::WORD_W;
               nxt_state.word = state_ff.word + 1'b1;
               if (lastWord) begin
                  nxt_state.memValid = 1'b0;
                  nxt_state.state    = S_DONE;
               end
            end
         end
         S_READ: begin
            if (memAck) begin
               nxt_state.work = {memRdata,
                                 state_ff.work[sakm_pkg::KEY_W-1:sakm_pkg::WORD_W]};
               nxt_state.word = state_ff.word + 1'b1;
               if (lastWord) begin
                  nxt_state.memValid = 1'b0;
                  nxt_state.state    = S_MIX;
               end
            end
         end
         S_DONE: begin
            // scrub working copy of the plaintext
            nxt_state.work  = sakm_pkg::KEY_RST;
            nxt_state.tag   = sakm_pkg::KEY_RST;
            nxt_state.cur.key = sakm_pkg::KEY_RST;
            nxt_state.out.key = sakm_pkg::KEY_RST;
            nxt_state.state = S_IDLE;
         end
         default: begin
            nxt_state.state = S_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers: reset zeroizes every secret
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_ff       <= '0;
         state_ff.state <= S_IDLE;
         state_ff.master <= sakm_pkg::KEY_RST;
         state_ff.wrap   <= sakm_pkg::KEY_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ---------------------------------------------------------------
   // outputs; root keys have no route here
   // ---------------------------------------------------------------
   always_comb begin
      memReq.valid = state_ff.memValid;
      memReq.write = (state_ff.state == S_WRITE);
      memReq.index = state_ff.cur.index;
      memReq.word  = state_ff.word;
      memReq.wdata = state_ff.work[sakm_pkg::WORD_W-1:0];
      rxMemReq     = state_ff.cur.dirTx ? '0 : memReq;
      txMemReq     = state_ff.cur.dirTx ? memReq : '0;
   end

   assign cmdReady   = (state_ff.state == S_IDLE);
   assign dpKey      = state_ff.out;
   assign keysLoaded = usable;
   assign cmdError   = state_ff.err;

endmodule : sakm_top
`default_nettype wire

/* shared/sakm_pkg.sv */
`default_nettype none
package sakm_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int KEY_W      = 256;
   localparam int IDX_W      = 8;
   localparam int WORD_W     = 32;
   localparam int ENTRY_WORDS = 8;
   localparam int WCNT_W     = 3;
   localparam int ROUNDS     = 4;
   localparam int RCNT_W     = 2;

   // ---------------------------------------------------------------
   // reset values and kdf label
   // ---------------------------------------------------------------
   localparam logic [KEY_W-1:0]  KEY_RST  = '0;
   localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0]       KDF_LABEL = 32'h5053_0001;

   typedef enum logic [1:0] {
      SAKM_DIR_RX,
      SAKM_DIR_TX
   } sakm_dir_t;

   typedef enum logic [1:0] {
      SAKM_OP_ADD,
      SAKM_OP_DELETE,
      SAKM_OP_FETCH,
      SAKM_OP_DERIVE
   } sakm_op_t;

   // control-plane command (from fifo)
   typedef struct packed {
      sakm_op_t          op;
      logic              dirTx;
      logic              keyIs256;
      logic [IDX_W-1:0]  index;
      logic [KEY_W-1:0]  key;
   } sakm_cmd_t;

   // association database memory request, one per direction
   typedef struct packed {
      logic                valid;
      logic                write;
      logic [IDX_W-1:0]    index;
      logic [WCNT_W-1:0]   word;
      logic [WORD_W-1:0]   wdata;
   } sakm_mem_req_t;

   // key delivered to the data plane
   typedef struct packed {
      logic              valid;
      logic              dirTx;
      logic              authOk;
      logic [KEY_W-1:0]  key;
   } sakm_dp_key_t;

endpackage : sakm_pkg
`default_nettype wire

/* sim/sakm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// one direction of the association table
// ----
module sakm_mem_model #(parameter logic [1:0] LAG = 2'h0) (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire sakm_pkg::sakm_mem_req_t  req,
   output logic                          ack,
   output logic [31:0]                   rdata
);
   logic [31:0] mem [0:2047];
   logic [1:0]  cnt;
   logic [31:0] last;
   assign ack = req.valid && (cnt == LAG);
   assign rdata = ack ? mem[{req.index, req.word}] : ~last;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt <= 2'h0;
      end else if (ack) begin
         cnt <= 2'h0;
         last <= rdata;
         if (req.write) begin
            mem[{req.index, req.word}] <= req.wdata;
         end
      end else if (req.valid) begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule : sakm_mem_model
`default_nettype wire

/* sim/sakm_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// key manager port checks
// ----
module sakm_properties (
   input wire logic                     clk,
   input wire logic                     rstn,
   input wire logic                     mkWrite,
   input wire logic                     wkWrite,
   input wire logic                     cmdValid,
   input wire logic                     cmdReady,
   input wire sakm_pkg::sakm_cmd_t      cmd,
   input wire logic                     ecbRequest,
   input wire sakm_pkg::sakm_mem_req_t  rxMemReq,
   input wire sakm_pkg::sakm_mem_req_t  txMemReq,
   input wire logic                     rxMemAck,
   input wire logic                     txMemAck,
   input wire sakm_pkg::sakm_dp_key_t   dpKey,
   input wire logic                     keysLoaded,
   input wire logic                     cmdError
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_take;
      cmdValid && cmdReady;
   endsequence
   sequence s_good;
      s_take ##0 keysLoaded && !ecbRequest;
   endsequence
   sequence s_quiet;
      !rxMemReq.valid && !txMemReq.valid && !dpKey.valid;
   endsequence
   property p_hold(sakm_pkg::sakm_mem_req_t r, logic a);
      r.valid && !a |=> $stable(r);
   endproperty
   a_reset_clear: assert property (disable iff (1'b0) !rstn |=> cmdReady && !keysLoaded
      && !cmdError && !dpKey.valid && !rxMemReq.valid && !txMemReq.valid) else $error("reset left state");
   a_refuse_ecb: assert property (s_take ##0 ecbRequest |=> cmdError ##0 s_quiet [*3])
      else $error("codebook request served");
   a_refuse_cold: assert property (s_take ##0 !keysLoaded |=> cmdError ##0 s_quiet)
      else $error("command served without keys");
   a_delete_zero: assert property (s_good ##0 cmd.op == sakm_pkg::SAKM_OP_DELETE && cmd.dirTx
      |=> txMemReq.valid && txMemReq.write && txMemReq.word == 0 && txMemReq.wdata == 0)
      else $error("delete did not write zero");
   a_busy_order: assert property (s_good |=> !cmdReady) else $error("second command open");
   a_dir_split: assert property (!(rxMemReq.valid && txMemReq.valid)) else $error("both ports");
   a_rx_hold: assert property (p_hold(rxMemReq, rxMemAck)) else $error("rx request moved");
   a_tx_hold: assert property (p_hold(txMemReq, txMemAck)) else $error("tx request moved");
   a_load_cause: assert property ($rose(keysLoaded) |-> $past(mkWrite) || $past(wkWrite))
      else $error("keys loaded without write");
endmodule : sakm_properties
`default_nettype wire

/* sim/sakm_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// key manager bench
// ----
module sakm_top_test;
   logic clk, rstn, mkWrite, wkWrite, cmdValid, cmdReady, ecbRequest;
   logic rxMemAck, txMemAck, keysLoaded, cmdError, err;
   logic [255:0] keyWdata;
   logic [31:0] rxMemRdata, txMemRdata;
   sakm_pkg::sakm_cmd_t cmd;
   sakm_pkg::sakm_mem_req_t rxMemReq, txMemReq;
   sakm_pkg::sakm_dp_key_t dpKey, got;
   int failures, comparisons;
   localparam logic [255:0] MK = {8{32'h1357_9BDF}};
   localparam logic [255:0] K1 = {8{32'h1234_5678}};
   localparam logic [255:0] K2 = {{4{32'hFFFF_FFFF}}, {4{32'h0C0B_0128}}};
   sakm_top uut (.clk, .rstn, .mkWrite, .wkWrite, .keyWdata, .cmdValid, .cmdReady, .cmd,
      .ecbRequest, .rxMemReq, .txMemReq, .rxMemAck, .txMemAck, .rxMemRdata, .txMemRdata,
      .dpKey, .keysLoaded, .cmdError);
   sakm_mem_model #(.LAG(2'h2)) rxMdl (.clk(clk), .rstn(rstn), .req(rxMemReq), .ack(rxMemAck),
      .rdata(rxMemRdata));
   sakm_mem_model txMdl (.clk(clk), .rstn(rstn), .req(txMemReq), .ack(txMemAck),
      .rdata(txMemRdata));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic bit miss(input bit b);
      comparisons++;
      return b;
   endfunction : miss
   task automatic bad(input string m);
      failures++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task automatic final_report();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic run(input sakm_pkg::sakm_op_t op, input logic tx, input logic w,
                      input logic [7:0] idx, input logic [255:0] k, input logic ecb);
      int i;
      err = 1'b0;
      got = '0;
      cmd = '{op, tx, w, idx, k};
      ecbRequest = ecb;
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      ecbRequest = 1'b0;
      for (i = 0; i < 300; i++) begin
         if (cmdError === 1'b1) err = 1'b1;
         if (dpKey.valid === 1'b1) got = dpKey;
         if (cmdReady === 1'b1) break;
         @(negedge clk);
      end
      if (i == 300) begin
         bad("no return to idle");
         final_report();
      end
   endtask : run
   task automatic load(input logic m);
      keyWdata = m ? MK : {8{32'h2468_ACE0}};
      mkWrite = m;
      wkWrite = !m;
      @(negedge clk);
      mkWrite = 1'b0;
      wkWrite = 1'b0;
   endtask : load
   task automatic t_cold();
      if (miss(cmdReady !== 1'b1 || keysLoaded !== 1'b0)) bad("reset state");
      run(sakm_pkg::SAKM_OP_DERIVE, 1'b1, 1'b1, 8'h05, K1, 1'b0);
      if (miss(err !== 1'b1 || got.valid !== 1'b0)) bad("cold command served");
      load(1'b1);
      load(1'b0);
      if (miss(keysLoaded !== 1'b1)) bad("keys not loaded");
      run(sakm_pkg::SAKM_OP_FETCH, 1'b1, 1'b1, 8'h05, K1, 1'b1);
      if (miss(err !== 1'b1 || got.valid !== 1'b0)) bad("codebook served");
      $display("cold, load and codebook done");
   endtask : t_cold
   task automatic t_add(input logic tx, input logic w, input logic [7:0] idx,
                        input logic [255:0] k, input logic [255:0] exp);
      int j;
      run(sakm_pkg::SAKM_OP_ADD, tx, w, idx, k, 1'b0);
      for (j = 0; j < 8; j++) begin
         if (miss((tx ? txMdl.mem[{idx, j[2:0]}] : rxMdl.mem[{idx, j[2:0]}]) === exp[j*32+:32]))
            bad("plain word stored");
      end
      run(sakm_pkg::SAKM_OP_FETCH, tx, w, idx, '0, 1'b0);
      if (miss(got.valid !== 1'b1 || got.dirTx !== tx || got.authOk !== 1'b1)) bad("fetch");
      if (miss(got.key !== exp)) bad("unwrapped key");
      $display("add and fetch done");
   endtask : t_add
   task automatic t_derive_delete();
      int j;
      run(sakm_pkg::SAKM_OP_DERIVE, 1'b1, 1'b1, 8'h05, '0, 1'b0);
      if (miss(got.valid !== 1'b1 || got.key === MK || got.key === '0)) bad("derive");
      run(sakm_pkg::SAKM_OP_DELETE, 1'b1, 1'b1, 8'h05, '0, 1'b0);
      for (j = 0; j < 8; j++) begin
         if (miss(txMdl.mem[{8'h05, j[2:0]}] !== 32'h0000_0000)) bad("word not zeroed");
      end
      if (miss(rxMdl.mem[{8'h09, 3'h0}] === 32'h0000_0000)) bad("other table hit");
      $display("derive and delete done");
   endtask : t_derive_delete
   task automatic t_rezero();
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      if (miss(keysLoaded !== 1'b0 || dpKey.valid !== 1'b0)) bad("reset kept keys");
      run(sakm_pkg::SAKM_OP_DERIVE, 1'b0, 1'b1, 8'h09, '0, 1'b0);
      if (miss(err !== 1'b1 || got.valid !== 1'b0)) bad("usable after reset");
      $display("zeroize done");
   endtask : t_rezero
   initial begin
      {rstn, mkWrite, wkWrite, cmdValid, ecbRequest} = '0;
      keyWdata = '0;
      cmd = '0;
      failures = 0;
      comparisons = 0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      t_cold();
      t_add(1'b1, 1'b1, 8'h05, K1, K1);
      t_add(1'b0, 1'b0, 8'h09, K2, {128'h0, K2[127:0]});
      t_derive_delete();
      t_rezero();
      final_report();
   end
endmodule : sakm_top_test
bind sakm_top sakm_properties chk (.clk, .rstn, .mkWrite, .wkWrite, .cmdValid, .cmdReady,
   .cmd, .ecbRequest, .rxMemReq, .txMemReq, .rxMemAck, .txMemAck, .dpKey, .keysLoaded,
   .cmdError);
`default_nettype wire
